//--- verilog/grid_defs.svh
`ifndef GRID_DEFS_SVH
`define GRID_DEFS_SVH
`define CLK_HZ        25000000
`define RST_MIN_MS    250
`define RST_MAX_MS    2000
`define FLASH_MS      125
`define NOISE_SCANS   3
`define CTRL_OFS      4'h0
`define STAT_OFS      4'h4
`define IRQ_STAT_OFS  4'h8
`define IRQ_MASK_OFS  4'hC
`define CTRL_RESET    1'b0
`define DISP_DASH     8'h2D
`define DISP_LATCH    8'h4C
`define IRQ_TRIP_BIT  0
`define IRQ_RST_BIT   1
`define IRQ_LOCK_BIT  2
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

//--- verilog/grid_pkg.sv
package grid_pkg;
	typedef enum logic [2:0] {
		ST_START = 3'b000,
		ST_RUN   = 3'b001,
		ST_TRIP  = 3'b010,
		ST_LATCH = 3'b011,
		ST_PWR   = 3'b100,
		ST_LOCK  = 3'b101
	} sup_state_type;
	typedef logic [1:0] resp_type;
endpackage

//--- verilog/light_grid_output_supervisor.sv
`timescale 1ns/1ps
`include "grid_defs.svh"
module light_grid_output_supervisor #(
	parameter int BEAMS         = 4,
	parameter int RESET_MIN_CYC = `RST_MIN_MS * (`CLK_HZ / 1000),
	parameter int RESET_MAX_CYC = `RST_MAX_MS * (`CLK_HZ / 1000),
	parameter int FLASH_CYC     = `FLASH_MS * (`CLK_HZ / 1000)
) (
	input  wire logic               clk_in,
	input  wire logic               reset_in,
	input  wire logic [BEAMS-1:0]   beam_blocked_in,
	input  wire logic [BEAMS-1:0]   beam_marginal_in,
	input  wire logic               reset_switch_in,
	input  wire logic               lockout_in,
	input  wire logic               noise_in,
	input  wire logic               scan_tick_in,
	output logic [1:0]              safety_switching_outputs_out,
	output logic                    status_red_out,
	output logic                    status_green_out,
	output logic [BEAMS-1:0]        beam_red_out,
	output logic [BEAMS-1:0]        beam_green_out,
	output logic                    reset_led_out,
	output logic [7:0]              display_out,
	output logic                    irq_out,
	input  wire logic [3:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output grid_pkg::resp_type      s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [3:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output grid_pkg::resp_type      s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);
	import grid_pkg::*;

	localparam int CW = 26;

	if (BEAMS < 2 || BEAMS > 8 || RESET_MIN_CYC < 1 || RESET_MAX_CYC <= RESET_MIN_CYC ||
		RESET_MAX_CYC >= (1 << CW) - 1 || FLASH_CYC < 1 || FLASH_CYC >= (1 << CW)) begin : g_bad
		$error("light_grid_output_supervisor: parameter out of range");
	end

	typedef struct packed {
		sup_state_type    state;
		logic [BEAMS-1:0] blk_s1, blk_s2, mrg_s1, mrg_s2;
		logic [3:0]       sync_s1, sync_s2;
		logic [3:0]       noise_cnt;
		logic [CW-1:0]    sw_cnt;
		logic [CW-1:0]    tick_cnt;
		logic [2:0]       phase;
		logic             latch_mode;
		logic [2:0]       irq_stat, irq_mask;
		logic [1:0]       safety;
		logic             stat_red, stat_green, rst_led;
		logic [BEAMS-1:0] beam_red, beam_green;
		logic [7:0]       disp;
		logic [3:0]       awaddr;
		logic             aw_got, w_got;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid, rvalid;
		resp_type         bresp, rresp;
		logic [31:0]      rdata;
	} st_type;

	st_type q, d;

	function automatic logic [2:0] reg_sel(input logic [3:0] a);
		case (a)
			`CTRL_OFS:     reg_sel = 3'h4;
			`STAT_OFS:     reg_sel = 3'h5;
			`IRQ_STAT_OFS: reg_sel = 3'h6;
			`IRQ_MASK_OFS: reg_sel = 3'h7;
			default:       reg_sel = 3'h0;
		endcase
	endfunction

	logic [BEAMS-1:0] blk, mrg, br, bg;
	logic             sw, lock, noisy, noise_trip, blocked, rst_valid, sw_closed_prev;
	logic             dbl, sgl, flick, outs_on;
	logic [2:0]       wsel, rsel, ev;

	assign blk   = q.blk_s2;
	assign mrg   = q.mrg_s2;
	assign sw    = q.sync_s2[0];
	assign lock  = q.sync_s2[1];
	assign noisy = q.sync_s2[2];
	assign sw_closed_prev = q.sync_s2[3];
	assign noise_trip = (q.noise_cnt >= 4'(`NOISE_SCANS));
	assign blocked = (|blk) || noise_trip;
	assign rst_valid = !sw && sw_closed_prev && (q.sw_cnt >= CW'(RESET_MIN_CYC)) &&
		(q.sw_cnt <= CW'(RESET_MAX_CYC));
	assign dbl   = (q.phase == 3'h0) || (q.phase == 3'h2);
	assign sgl   = (q.phase == 3'h0);
	assign flick = q.phase[0];
	assign wsel  = reg_sel(q.awaddr);
	assign rsel  = reg_sel(s_axi_araddr);

	for (genvar i = 0; i < BEAMS; i++) begin : g_beam
		if (i == 0) begin : g_sync
			assign br[i] = blk[0];
			assign bg[i] = !blk[0] && (!mrg[0] || flick);
		end else begin : g_other
			assign br[i] = !blk[0] && blk[i];
			assign bg[i] = !blk[0] && !blk[i] && (!mrg[i] || flick);
		end
	end

	always_comb begin
		d = q;
		ev = 3'h0;
		d.blk_s1  = beam_blocked_in;
		d.blk_s2  = q.blk_s1;
		d.mrg_s1  = beam_marginal_in;
		d.mrg_s2  = q.mrg_s1;
		d.sync_s1 = {1'b0, noise_in, lockout_in, reset_switch_in};
		d.sync_s2 = {q.sync_s2[0], q.sync_s1[2:0]};
		if (scan_tick_in) begin
			d.noise_cnt = !noisy ? 4'h0 : (noise_trip ? q.noise_cnt : q.noise_cnt + 4'h1);
		end
		d.sw_cnt = !sw ? '0 : (q.sw_cnt > CW'(RESET_MAX_CYC) ? q.sw_cnt : q.sw_cnt + 1'b1);
		if (q.tick_cnt == CW'(FLASH_CYC - 1)) begin
			d.tick_cnt = '0;
			d.phase = q.phase + 3'h1;
		end else begin
			d.tick_cnt = q.tick_cnt + 1'b1;
		end
		case (q.state)
			ST_START: d.state = q.latch_mode ? ST_PWR : ST_RUN;
			ST_RUN:   if (blocked) d.state = q.latch_mode ? ST_LATCH : ST_TRIP;
			ST_TRIP: begin
				if (q.latch_mode) d.state = ST_LATCH;
				else if (!blocked) d.state = ST_RUN;
			end
			ST_LATCH, ST_PWR: if (rst_valid && !blocked) d.state = ST_RUN;
			ST_LOCK:  d.state = ST_LOCK;
			default:  d.state = ST_START;
		endcase
		if (lock) d.state = ST_LOCK;
		outs_on = (d.state == ST_RUN) && !blocked && !lock;
		d.safety = {2{outs_on}};
		if (q.safety[0] && !outs_on) ev[`IRQ_TRIP_BIT] = 1'b1;
		if ((q.state == ST_LATCH || q.state == ST_PWR) && d.state == ST_RUN) ev[`IRQ_RST_BIT] = 1'b1;
		if (lock && q.state != ST_LOCK) ev[`IRQ_LOCK_BIT] = 1'b1;
		d.beam_red   = br;
		d.beam_green = bg;
		d.disp = q.latch_mode ? `DISP_LATCH : `DISP_DASH;
		case (q.state)
			ST_LOCK: begin
				d.stat_red = sgl;
				d.stat_green = 1'b0;
				d.rst_led = 1'b0;
			end
			ST_LATCH, ST_PWR: begin
				d.stat_red = 1'b1;
				d.stat_green = 1'b0;
				d.rst_led = dbl;
			end
			default: begin
				d.stat_red = blocked;
				d.stat_green = !blocked && q.state == ST_RUN;
				d.rst_led = 1'b1;
			end
		endcase
		if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = (wsel == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
			if (q.wstrb[0]) begin
				if (wsel == 3'h4) d.latch_mode = q.wdata[0];
				if (wsel == 3'h6) d.irq_stat = q.irq_stat & ~q.wdata[2:0];
				if (wsel == 3'h7) d.irq_mask = q.wdata[2:0];
			end
		end else if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		d.irq_stat = d.irq_stat | ev;
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp  = (rsel == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
			case (rsel)
				3'h4:    d.rdata = {31'h0, q.latch_mode};
				3'h5:    d.rdata = {16'h0, 8'(blk), 2'h0, noise_trip, q.safety[0], 1'b0, q.state};
				3'h6:    d.rdata = {29'h0, q.irq_stat};
				3'h7:    d.rdata = {29'h0, q.irq_mask};
				default: d.rdata = 32'h0;
			endcase
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			q <= '0;
			q.latch_mode <= `CTRL_RESET;
			q.disp <= `DISP_DASH;
		end else begin
			q <= d;
		end
	end

	assign safety_switching_outputs_out = q.safety;
	assign status_red_out   = q.stat_red;
	assign status_green_out = q.stat_green;
	assign beam_red_out     = q.beam_red;
	assign beam_green_out   = q.beam_green;
	assign reset_led_out    = q.rst_led;
	assign display_out      = q.disp;
	assign irq_out          = |(q.irq_stat & q.irq_mask);
	assign s_axi_awready    = !q.aw_got && !q.bvalid;
	assign s_axi_wready     = !q.w_got && !q.bvalid;
	assign s_axi_bvalid     = q.bvalid;
	assign s_axi_bresp      = q.bresp;
	assign s_axi_arready    = !q.rvalid;
	assign s_axi_rvalid     = q.rvalid;
	assign s_axi_rdata      = q.rdata;
	assign s_axi_rresp      = q.rresp;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	chk_block_drops: assert property (blocked |=> q.safety == 2'b00)
		else $error("outputs stayed on while blocked");
	chk_sync_beam: assert property (blk[0] |=> q.beam_red[0] && q.beam_red[BEAMS-1:1] == '0 &&
		q.beam_green == '0)
		else $error("sync beam blocked but other indicators lit");
	chk_status_red: assert property (blocked && q.state != ST_LOCK |=> q.stat_red && !q.stat_green)
		else $error("status not red while blocked");
	chk_beam_green: assert property (!blk[0] && !blk[1] && !mrg[1] |=> q.beam_green[1] && !q.beam_red[1])
		else $error("clear beam not steady green");
	chk_disp_mode: assert property (##1 q.disp == ($past(q.latch_mode) ? `DISP_LATCH : `DISP_DASH))
		else $error("display does not match mode");
	chk_latch_hold: assert property (q.state == ST_LATCH && !rst_valid |=> q.state != ST_RUN)
		else $error("latched state left without reset");
	chk_lock_leds: assert property (q.state == ST_LOCK |=> !q.rst_led && !q.stat_green && q.safety == 2'b00)
		else $error("lockout indication wrong");
	chk_trip_auto: assert property (q.state == ST_TRIP && !blocked && !q.latch_mode && !lock
		|=> q.state == ST_RUN)
		else $error("trip mode did not restart");
	chk_reset_window: assert property ((q.state == ST_LATCH || q.state == ST_PWR) && !lock &&
		q.sw_cnt < CW'(RESET_MIN_CYC) |=> q.state != ST_RUN)
		else $error("reset accepted outside window");
	chk_pwr_off: assert property (q.state == ST_PWR |-> q.safety == 2'b00 ##1 q.safety == 2'b00)
		else $error("outputs on before power-up reset");
	chk_reset_led: assert property ((q.state == ST_PWR || q.state == ST_LATCH) && rst_valid && !blocked && !lock
		|=> ##1 q.rst_led)
		else $error("reset indicator not steady after reset");
	chk_latch_red: assert property (q.state == ST_LATCH |=> q.stat_red)
		else $error("latched status not red");
	chk_noise_filter: assert property (q.noise_cnt < 4'(`NOISE_SCANS) && !(|blk) && !lock && q.state == ST_RUN
		|=> q.safety == 2'b11)
		else $error("noise acted too early");

	cov_trip_cycle: cover property (q.state == ST_TRIP ##1 q.state == ST_RUN);
	cov_latch_reset: cover property (q.state == ST_LATCH ##1 q.state == ST_RUN);
	cov_lockout: cover property (q.state == ST_LOCK);
endmodule

//--- sim/machine_side_model.sv
`timescale 1ns/1ps
module machine_side_model (
	input  wire logic       clk_in,
	input  wire logic [1:0] safety_in,
	input  wire logic       press_go_in,
	input  wire logic [7:0] press_len_in,
	output logic            reset_switch_out,
	output logic            machine_running_out
);
	int left_q = 0;
	initial reset_switch_out = 1'b0;
	// The switch stays closed for the asked span, then reopens as an operator would.
	always @(posedge clk_in) begin
		if (press_go_in && left_q == 0) begin
			left_q <= press_len_in;
			reset_switch_out <= 1'b1;
		end else if (left_q > 1) begin
			left_q <= left_q - 1;
		end else begin
			left_q <= 0;
			reset_switch_out <= 1'b0;
		end
	end
	// The machine moves only while both channels are on.
	assign machine_running_out = &safety_in;
endmodule

//--- sim/light_grid_output_supervisor_bench.sv
`timescale 1ns/1ps
module light_grid_output_supervisor_bench;
	import grid_pkg::*;
	logic clk_in = 0, reset_in = 1, reset_switch_in, lockout_in = 0, noise_in = 0, scan_tick_in = 0, irq_out;
	logic [3:0] beam_blocked_in = 0, beam_marginal_in = 0, beam_red_out, beam_green_out, s_axi_awaddr = 0;
	logic [3:0] s_axi_wstrb = 4'hF, s_axi_araddr = 0;
	logic [1:0] safety_switching_outputs_out;
	logic status_red_out, status_green_out, reset_led_out, running, press_go = 0;
	logic [7:0] display_out, press_len = 0;
	logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready, s_axi_bvalid, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	resp_type s_axi_bresp, s_axi_rresp, r;
	int fail_count = 0, n_compared = 0, n;
	always #20 clk_in = ~clk_in;
	light_grid_output_supervisor #(.BEAMS(4), .RESET_MIN_CYC(10), .RESET_MAX_CYC(40), .FLASH_CYC(2)) uut (
		.clk_in, .reset_in, .beam_blocked_in, .beam_marginal_in, .reset_switch_in, .lockout_in, .noise_in,
		.scan_tick_in, .safety_switching_outputs_out, .status_red_out, .status_green_out, .beam_red_out,
		.beam_green_out, .reset_led_out, .display_out, .irq_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	machine_side_model partner (.clk_in, .safety_in(safety_switching_outputs_out), .press_go_in(press_go),
		.press_len_in(press_len), .reset_switch_out(reset_switch_in), .machine_running_out(running));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int t = 0;
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge clk_in);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
			if (s_axi_bvalid === 1'b1) s_axi_bready <= 0;
		end while (s_axi_bvalid !== 1'b1 && ++t < 60);
		if (s_axi_bvalid !== 1'b1) fail_count++;
		r = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		int t = 0;
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge clk_in);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1 && ++t < 60);
		if (s_axi_rvalid !== 1'b1) fail_count++;
		s_axi_rready <= 0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic settle(input logic [3:0] b);
		@(posedge clk_in);
		beam_blocked_in <= b;
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic press(input logic [7:0] len);
		@(posedge clk_in);
		press_go <= 1;
		press_len <= len;
		@(posedge clk_in);
		press_go <= 0;
		repeat (len + 8) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic test_run_and_trip();
		settle(4'h0);
		check("safety", 2'b11, safety_switching_outputs_out);
		check("status", 2'b01, {status_red_out, status_green_out});
		check("beam green", 4'hF, beam_green_out);
		check("reset led", 1, reset_led_out);
		check("display", 8'h2D, display_out);
		@(posedge clk_in);
		beam_marginal_in <= 4'h8;
		settle(4'h0);
		n = 0;
		repeat (16) begin @(negedge clk_in); n += beam_green_out[3]; end
		check("flicker count", 8, n);
		@(posedge clk_in);
		beam_marginal_in <= 4'h0;
		settle(4'h2);
		check("safety", 0, safety_switching_outputs_out);
		check("status red", 2'b10, {status_red_out, status_green_out});
		check("beam red", 4'h2, beam_red_out);
		settle(4'h1);
		check("beam outputs", 8'h10, {beam_red_out, beam_green_out});
		settle(4'h0);
		check("beam green", 4'hF, beam_green_out);
		check("safety", 2'b11, safety_switching_outputs_out);
		check("machine running", 1, running);
		$display("test run and trip done");
	endtask
	task automatic test_noise();
		logic [31:0] d;
		@(posedge clk_in);
		noise_in <= 1;
		repeat (3) @(posedge clk_in);
		repeat (4) begin
			@(posedge clk_in);
			scan_tick_in <= 1;
			@(posedge clk_in);
			scan_tick_in <= 0;
			repeat (3) @(negedge clk_in);
			check("noise safety", n < 2 ? 2'b11 : 2'b00, safety_switching_outputs_out);
			n++;
		end
		@(posedge clk_in);
		noise_in <= 0;
		repeat (3) @(posedge clk_in);
		scan_tick_in <= 1;
		@(posedge clk_in);
		scan_tick_in <= 0;
		repeat (5) @(negedge clk_in);
		check("noise cleared", 2'b11, safety_switching_outputs_out);
		axi_rd(4'h2, d);
		check("unmapped resp", 2'h2, r);
		$display("test noise done");
	endtask
	task automatic test_latch();
		logic [31:0] d;
		axi_wr(4'h0, 1);
		check("write resp", 2'h0, r);
		axi_rd(4'h0, d);
		check("ctrl readback", 1, d);
		axi_wr(4'h8, 7);
		axi_wr(4'hC, 1);
		settle(4'h4);
		check("irq", 1, irq_out);
		axi_wr(4'h8, 1);
		check("irq cleared", 0, irq_out);
		settle(4'h0);
		check("latched", 3'b100, {status_red_out, safety_switching_outputs_out});
		check("beam green", 4'hF, beam_green_out);
		n = 0;
		repeat (16) begin @(negedge clk_in); n += reset_led_out; end
		check("double flash", 4, n);
		press(5);
		check("short press", 0, safety_switching_outputs_out);
		press(20);
		check("reset ok", 3'b111, {reset_led_out, safety_switching_outputs_out});
		check("machine running", 1, running);
		check("display", 8'h4C, display_out);
		$display("test latch done");
	endtask
	task automatic test_lockout();
		lockout_in <= 1;
		repeat (6) @(negedge clk_in);
		check("lockout", 4'b0000, {reset_led_out, status_green_out, safety_switching_outputs_out});
		n = 0;
		repeat (16) begin @(negedge clk_in); n += status_red_out; end
		check("single flash", 2, n);
		$display("test lockout done");
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		reset_in <= 0;
		test_run_and_trip();
		n = 0;
		test_noise();
		test_latch();
		test_lockout();
		final_report();
	end
	initial begin
		repeat (5000) @(posedge clk_in);
		fail_count++;
		final_report();
	end
endmodule
